// File: design/an_fault_regs.svh
`ifndef AN_FAULT_REGS_SVH
`define AN_FAULT_REGS_SVH

// Register map of the management port.
`define ADVERT_ADDR 5'h04
`define ADVERT_RESET 16'h0000
// Writable bits of the advertisement register: 15, 13:12, 8:5.
`define ADVERT_WMASK 16'hB1E0
`define ADVERT_MP_BIT 15
`define ADVERT_FC_HI 13
`define ADVERT_FC_LO 12
`define ADVERT_HD_BIT 6
`define ADVERT_FD_BIT 5

// The retiming pipe resets to TRUE so that reset itself never looks like a lost link.
`define SYNC_PIPE_RESET 2'h3

// Fault codes.
`define FAULT_NONE 2'h0
`define FAULT_LINK 2'h2
`define FAULT_ANERR 2'h3

// Next page message fields.
`define NP_MSG_RF 11'h004
`define NP_MSG_PAGE_BIT 13
`define NP_MP_BIT 15
`define NP_TOGGLE_BIT 11
`define NP_CODE_HI 10

`endif

// File: design/an_fault_pkg.sv
`default_nettype none
package an_fault_pkg;

    typedef enum logic [1:0] {
        PG_BASE,
        PG_MSG,
        PG_UNF
    } page_e;

    typedef enum logic [1:0] {
        DETAIL_TEST,
        DETAIL_LINK_LOSS,
        DETAIL_JABBER,
        DETAIL_PARALLEL
    } detail_e;

endpackage
`default_nettype wire

// File: design/fault_pager.sv
`timescale 1ns/100ps
`default_nettype none
`include "an_fault_regs.svh"

// Builds the fault message page and the unformatted page that follows it.
module fault_pager (
    input wire logic clk, // Clock.
    input wire logic rst, // Synchronous reset.
    input wire logic start, // Begin a two-page fault exchange.
    input wire logic [1:0] detail, // Fault detail code.
    input wire logic page_ack, // Far end took the current page.
    output logic active, // Pages are being sent.
    output logic [15:0] page // Next page word.
);

    typedef struct packed {
        an_fault_pkg::page_e pg;
        logic [1:0] detail;
        logic toggle;
    } pager_s;

    pager_s st;
    pager_s next_st;

    always_comb
    begin
        next_st = st;
        case (st.pg)
            an_fault_pkg::PG_BASE:
            begin
                if (start)
                begin
                    next_st.pg = an_fault_pkg::PG_MSG;
                    next_st.detail = detail;
                end
            end
            an_fault_pkg::PG_MSG:
            begin
                if (page_ack)
                begin
                    next_st.pg = an_fault_pkg::PG_UNF;
                    next_st.toggle = ~st.toggle;
                end
            end
            default:
            begin
                if (page_ack)
                begin
                    next_st.pg = an_fault_pkg::PG_BASE;
                    next_st.toggle = ~st.toggle;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '{an_fault_pkg::PG_BASE, 2'h0, 1'b0};
        else
            st <= next_st;
    end

    always_comb
    begin
        page = 16'h0000;
        page[`NP_TOGGLE_BIT] = st.toggle;
        if (st.pg == an_fault_pkg::PG_MSG)
        begin
            page[`NP_MP_BIT] = 1'b1;
            page[`NP_MSG_PAGE_BIT] = 1'b1;
            page[`NP_CODE_HI:0] = `NP_MSG_RF;
        end
        else if (st.pg == an_fault_pkg::PG_UNF)
            page[`NP_CODE_HI:0] = {9'h000, st.detail};
    end

    assign active = (st.pg != an_fault_pkg::PG_BASE);

    unf_follows_a: assert property (@(posedge clk) disable iff (rst)
        (st.pg == an_fault_pkg::PG_MSG && page_ack) |=> (st.pg == an_fault_pkg::PG_UNF && !page[`NP_MSG_PAGE_BIT]))
        else $error("unformatted page did not follow message page");

endmodule
`default_nettype wire

// File: design/autoneg_remote_fault_advert.sv
// What this block does
// - Send fault code 0b10 to report an earlier link failure.
// - Record a link failure while the sync flag shows FAIL.
// - Send the stored link-failure code only after sync returns TRUE.
// - Send fault code 0b11 when abilities cannot resolve to a common duplex.
// - Hold a sent fault code unchanged until handshake-done in base page exchange; only self-set codes are held, a register-written code follows each write.
// - For extra detail, send a next page message with code 4.
// - The following unformatted page carries fault detail 0, 1, 2 or 3.
// - Provide a 16-bit advertisement register with the documented fields.
// - Reserved advertisement bits are read-only and read as zero.
// - Convert the advertisement register into transmitted base pages.
// - Provide this register function through the block's own port.
// - Base pages copy bits 15, 13:12, 8:5; other bits go out zero.
`timescale 1ns/100ps
`default_nettype none
`include "an_fault_regs.svh"

module autoneg_remote_fault_advert (
    input wire logic clk, // 40 MHz clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [4:0] mgmt_addr, // Management register address.
    input wire logic mgmt_wr, // Management write strobe.
    input wire logic mgmt_rd, // Management read strobe.
    input wire logic [15:0] mgmt_wdata, // Management write data.
    output logic [15:0] mgmt_rdata, // Management read data, valid the cycle after mgmt_rd.
    input wire logic negotiation_sync_flag, // Sync status from the receive path, high when TRUE.
    input wire logic [15:0] partner_base, // Partner base page as received.
    input wire logic partner_valid, // Partner base page has been matched.
    input wire logic handshake_done, // Negotiation entered handshake-done in base page exchange.
    input wire logic fault_detail_req, // Request a fault message and unformatted page.
    input wire logic [1:0] fault_detail, // Detail code for that unformatted page.
    input wire logic page_ack, // Far end acknowledged the current next page.
    output logic [15:0] tx_config, // Configuration word to transmit.
    output logic [1:0] fault_code, // Fault code currently transmitted.
    output logic next_page_active // Fault next pages are being sent.
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] advert;
        logic [1:0] sync_pipe;
        logic link_failed;
        logic [1:0] self_fault;
        logic [15:0] rdata;
        logic [15:0] tx;
        logic [1:0] fc_out;
        logic np_out;
        logic detail_pend;
        logic [1:0] detail_code;
    } state_s;

    state_s st;
    state_s next_st;

    logic sync_ok;
    logic incompatible;
    logic pager_active;
    logic pager_start;
    logic [15:0] pager_page;
    logic [1:0] eff_fault;

    // The raw sync flag comes from the receive clock path, so it is retimed first.
    assign sync_ok = st.sync_pipe[1];

    // Duplex resolution fails when the two ends share no duplex mode.
    assign incompatible = partner_valid &&
        !((st.advert[`ADVERT_FD_BIT] && partner_base[`ADVERT_FD_BIT]) ||
          (st.advert[`ADVERT_HD_BIT] && partner_base[`ADVERT_HD_BIT]));

    // A self-set code overrides what software wrote into the register.
    assign eff_fault = (st.self_fault != `FAULT_NONE) ? st.self_fault
        : st.advert[`ADVERT_FC_HI:`ADVERT_FC_LO];

    assign pager_start = st.detail_pend && handshake_done && !pager_active;

    fault_pager u_pager (
        .clk(clk),
        .rst(rst),
        .start(pager_start),
        .detail(st.detail_code),
        .page_ack(page_ack),
        .active(pager_active),
        .page(pager_page)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        next_st.sync_pipe = {st.sync_pipe[0], negotiation_sync_flag};
        if (mgmt_wr && mgmt_addr == `ADVERT_ADDR)
            next_st.advert = mgmt_wdata & `ADVERT_WMASK;
        if (mgmt_rd)
        begin
            if (mgmt_addr == `ADVERT_ADDR)
                next_st.rdata = st.advert;
            else
                next_st.rdata = 16'h0000;
        end
        if (!sync_ok)
            next_st.link_failed = 1'b1;
        // A code in flight is frozen until handshake-done; a link failure recorded meanwhile is kept past it only while sync is still FAIL.
        if (handshake_done)
        begin
            next_st.self_fault = `FAULT_NONE;
            next_st.link_failed = !sync_ok;
        end
        else if (st.self_fault == `FAULT_NONE)
        begin
            if (incompatible)
                next_st.self_fault = `FAULT_ANERR;
            else if (st.link_failed && sync_ok)
                next_st.self_fault = `FAULT_LINK;
        end
        if (fault_detail_req)
        begin
            next_st.detail_pend = 1'b1;
            next_st.detail_code = fault_detail;
        end
        else if (pager_start)
            next_st.detail_pend = 1'b0;
        next_st.fc_out = eff_fault;
        next_st.np_out = pager_active;
        if (pager_active)
            next_st.tx = pager_page;
        else
        begin
            next_st.tx = st.advert & `ADVERT_WMASK;
            next_st.tx[`ADVERT_FC_HI:`ADVERT_FC_LO] = eff_fault;
            if (st.detail_pend)
                next_st.tx[`ADVERT_MP_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '{`ADVERT_RESET, `SYNC_PIPE_RESET, 1'b0, `FAULT_NONE, 16'h0000, 16'h0000, `FAULT_NONE, 1'b0, 1'b0, 2'h0};
        else
            st <= next_st;
    end

    assign mgmt_rdata = st.rdata;
    assign tx_config = st.tx;
    assign fault_code = st.fc_out;
    assign next_page_active = st.np_out;

    // ************************************************************
    // Checks
    // ************************************************************
    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        (st.advert & ~`ADVERT_WMASK) == 16'h0000)
        else $error("reserved advertisement bit set");

    advert_write_a: assert property (@(posedge clk) disable iff (rst)
        (mgmt_wr && mgmt_addr == `ADVERT_ADDR) |=> st.advert == ($past(mgmt_wdata) & `ADVERT_WMASK))
        else $error("advertisement write not stored");

    base_copy_a: assert property (@(posedge clk) disable iff (rst)
        (!pager_active && st.self_fault == `FAULT_NONE && !st.detail_pend) |=> tx_config == $past(st.advert))
        else $error("base page does not match register");

    anerr_code_a: assert property (@(posedge clk) disable iff (rst)
        (incompatible && !handshake_done && st.self_fault == `FAULT_NONE) |=> ##1 fault_code == `FAULT_ANERR)
        else $error("negotiation error code not sent");

    fault_hold_a: assert property (@(posedge clk) disable iff (rst)
        (st.self_fault != `FAULT_NONE && !handshake_done) |=> $stable(st.self_fault))
        else $error("fault code changed before handshake-done");

    fault_clear_a: assert property (@(posedge clk) disable iff (rst)
        handshake_done |=> st.self_fault == `FAULT_NONE)
        else $error("self fault not cleared");

    link_record_a: assert property (@(posedge clk) disable iff (rst)
        (!sync_ok && !handshake_done) |=> st.link_failed)
        else $error("link failure not recorded");

    link_wait_a: assert property (@(posedge clk) disable iff (rst)
        (!sync_ok && $past(st.self_fault) == `FAULT_NONE) |=> st.self_fault != `FAULT_LINK || $past(st.self_fault) == `FAULT_LINK)
        else $error("link code sent while sync failed");

    link_code_a: assert property (@(posedge clk) disable iff (rst)
        (st.self_fault == `FAULT_LINK) |=> ##1 (fault_code == `FAULT_LINK || $past(handshake_done, 2) || $past(handshake_done)))
        else $error("link failure code not transmitted");

    msg_page_a: assert property (@(posedge clk) disable iff (rst)
        pager_start |=> ##1 (next_page_active && tx_config[10:0] == `NP_MSG_RF))
        else $error("fault message page not sent");

    convert_a: assert property (@(posedge clk) disable iff (rst)
        !pager_active |=> (tx_config & ~`ADVERT_WMASK) == 16'h0000)
        else $error("reserved bit in base page");

    rdata_advert_a: assert property (@(posedge clk) disable iff (rst)
        (mgmt_rd && mgmt_addr == `ADVERT_ADDR) |=> mgmt_rdata == $past(st.advert))
        else $error("advertisement read data wrong");

    rdata_unmapped_a: assert property (@(posedge clk) disable iff (rst)
        (mgmt_rd && mgmt_addr != `ADVERT_ADDR) |=> mgmt_rdata == 16'h0000)
        else $error("unmapped read not zero");

    more_pages_a: assert property (@(posedge clk) disable iff (rst)
        (st.detail_pend && !pager_active) |=> tx_config[`ADVERT_MP_BIT])
        else $error("more pages flag not sent");

    fault_in_page_a: assert property (@(posedge clk) disable iff (rst)
        (st.self_fault != `FAULT_NONE && !pager_active) |=> tx_config[`ADVERT_FC_HI:`ADVERT_FC_LO] == $past(st.self_fault))
        else $error("self fault missing from base page");

    link_after_sync_a: assert property (@(posedge clk) disable iff (rst)
        (st.self_fault == `FAULT_NONE && !sync_ok) |=> st.self_fault != `FAULT_LINK)
        else $error("link code raised while sync failed");

    np_out_a: assert property (@(posedge clk) disable iff (rst)
        pager_active |=> next_page_active)
        else $error("next page activity not shown");

endmodule
`default_nettype wire

// File: tb/link_partner_model.sv
`timescale 1ns/100ps
`default_nettype none

// Far end: offers a base page and takes each fault next page after a settable delay.
module link_partner_model (
    input wire logic clk, // Clock.
    input wire logic rst, // Synchronous reset.
    input wire logic [15:0] offer, // Base page to offer.
    input wire logic offer_on, // Offer is being received.
    input wire logic [3:0] ack_delay, // Cycles before each acknowledge, at least 1.
    input wire logic active, // Next pages are being sent.
    input wire logic [15:0] tx_word, // Word seen on the medium.
    output logic [15:0] partner_base, // Received base page.
    output logic partner_valid, // Base page matched.
    output logic page_ack, // Current page taken.
    output logic [15:0] last_page, // Page taken at the last acknowledge.
    output logic [7:0] taken // Pages taken so far.
);
    logic [15:0] seen;
    logic [3:0] cnt;

    // An unmatched page shows the inverse, so stale data can never pass for a match.
    assign partner_base = offer_on ? offer : ~offer;
    assign partner_valid = offer_on;

    always_ff @(posedge clk)
    begin
        page_ack <= 1'b0;
        if (rst)
        begin
            cnt <= 4'h0;
            seen <= 16'h0000;
            taken <= 8'h00;
        end
        else if (cnt != 4'h0)
        begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1)
            begin
                page_ack <= 1'b1;
                last_page <= tx_word;
                taken <= taken + 8'h01;
            end
        end
        else if (active && tx_word !== seen)
        begin
            seen <= tx_word;
            cnt <= ack_delay;
        end
    end
endmodule
`default_nettype wire

// File: tb/autoneg_remote_fault_advert_tb.sv
`timescale 1ns/100ps
`default_nettype none

module autoneg_remote_fault_advert_tb;
    logic clk = 1'b0, rst = 1'b1, mgmt_wr = 1'b0, mgmt_rd = 1'b0, sync = 1'b1, hs = 1'b0, req = 1'b0, offer_on = 1'b0;
    logic [4:0] mgmt_addr = 5'h00;
    logic [1:0] detail = 2'h0;
    logic [3:0] ack_delay = 4'h1;
    logic [15:0] mgmt_wdata = 16'h0000, offer = 16'h0000;
    logic [15:0] mgmt_rdata, tx_config, partner_base, last_page, msg;
    logic [1:0] fault_code;
    logic next_page_active, partner_valid, page_ack;
    logic [7:0] taken, t0;
    int mismatches = 0, n_checks = 0, i;
    logic [15:0] vals [4] = '{16'h0020, 16'h4020, 16'h7020, 16'hFFFF};

    always #12.5 clk = ~clk;

    autoneg_remote_fault_advert DUT (.clk(clk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .negotiation_sync_flag(sync),
        .partner_base(partner_base), .partner_valid(partner_valid), .handshake_done(hs),
        .fault_detail_req(req), .fault_detail(detail), .page_ack(page_ack), .tx_config(tx_config),
        .fault_code(fault_code), .next_page_active(next_page_active));

    link_partner_model partner (.clk(clk), .rst(rst), .offer(offer), .offer_on(offer_on),
        .ack_delay(ack_delay), .active(next_page_active), .tx_word(tx_config), .partner_base(partner_base),
        .partner_valid(partner_valid), .page_ack(page_ack), .last_page(last_page), .taken(taken));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_addr <= a;
        mgmt_wdata <= d;
        mgmt_wr <= 1'b1;
        @(posedge clk);
        mgmt_wr <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        mgmt_addr <= a;
        mgmt_rd <= 1'b1;
        @(posedge clk);
        mgmt_rd <= 1'b0;
        repeat (2) @(posedge clk);
        check(mgmt_rdata, exp);
    endtask

    task automatic wait_fc(input logic [1:0] exp);
        for (i = 0; i < 12 && fault_code !== exp; i++)
            @(posedge clk);
        check({14'h0, fault_code}, {14'h0, exp});
    endtask

    task automatic handshake();
        hs <= 1'b1;
        @(posedge clk);
        hs <= 1'b0;
        @(posedge clk);
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence.
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(5'h04, 16'h0000);
        foreach (vals[k])
        begin
            wr(5'h04, vals[k]);
            check(tx_config, vals[k] & 16'hB1E0);
            rd(5'h04, vals[k] & 16'hB1E0);
        end
        wr(5'h05, 16'hFFFF);
        rd(5'h05, 16'h0000);
        rd(5'h04, 16'hB1E0);
        wr(5'h04, 16'h0060);
        sync <= 1'b0;
        repeat (6) @(posedge clk);
        check({14'h0, fault_code}, 16'h0000);
        sync <= 1'b1;
        wait_fc(2'h2);
        check(tx_config, 16'h2060);
        // A management write to the fault field must not disturb a held code.
        wr(5'h04, 16'h1060);
        repeat (20) @(posedge clk);
        check({14'h0, fault_code}, 16'h0002);
        handshake();
        wait_fc(2'h1);
        wr(5'h04, 16'h0020);
        offer <= 16'h0040;
        offer_on <= 1'b1;
        wait_fc(2'h3);
        offer_on <= 1'b0;
        repeat (20) @(posedge clk);
        check(tx_config, 16'h3020);
        handshake();
        wait_fc(2'h0);
        offer <= 16'h0060;
        offer_on <= 1'b1;
        repeat (8) @(posedge clk);
        check({14'h0, fault_code}, 16'h0000);
        for (int d = 0; d < 4; d++)
        begin
            ack_delay <= (d % 2 == 1) ? 4'h6 : 4'h1;
            detail <= d[1:0];
            req <= 1'b1;
            @(posedge clk);
            req <= 1'b0;
            repeat (3) @(posedge clk);
            check({15'h0, tx_config[15]}, 16'h0001);
            t0 = taken;
            handshake();
            for (i = 0; i < 40 && taken !== t0 + 8'h01; i++)
                @(posedge clk);
            msg = last_page;
            check(msg & 16'hF7FF, 16'hA004);
            for (i = 0; i < 40 && taken !== t0 + 8'h02; i++)
                @(posedge clk);
            check(last_page & 16'hF7FF, {14'h0, d[1:0]});
            check({15'h0, last_page[11]}, {15'h0, ~msg[11]});
            repeat (4) @(posedge clk);
            check({15'h0, next_page_active}, 16'h0000);
        end
        print_verdict();
    end

    initial
    begin
        #500000;
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
